// ### src/pmc_pkg.sv
/*
 * Package for the power-management restart trap and CPU clock switch.
 * Holds the command port map, field positions, reset values, the fixed
 * restart address ranges and the timing constants.
 * Assumes a 100 MHz system clock.
 */
package pmc_pkg;

    // System clock period in picoseconds
    localparam int unsigned CLK_PS = 10000;

    // Register indices on the plain command port
    localparam logic [3:0] REG_RESTART_EN = 4'h0;
    localparam logic [3:0] REG_PROG0_BASE = 4'h1;
    localparam logic [3:0] REG_PROG0_MASK = 4'h2;
    localparam logic [3:0] REG_PROG1_BASE = 4'h3;
    localparam logic [3:0] REG_PROG1_MASK = 4'h4;
    localparam logic [3:0] REG_TIME_BASE = 4'h5;
    localparam logic [3:0] REG_STOP_CFG = 4'h6;
    localparam logic [3:0] REG_COMMAND = 4'h7;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam logic [3:0] REG_IRQ_STAT = 4'h9;
    localparam logic [3:0] REG_IRQ_EN = 4'hA;
    localparam logic [3:0] REG_IRQ_CLR = 4'hB;

    // Restart enable bits
    localparam int EN_COM1 = 0;
    localparam int EN_COM2 = 1;
    localparam int EN_LPT = 2;
    localparam int EN_DISK = 3;
    localparam int EN_VGA = 4;
    localparam int EN_KB = 5;
    localparam int EN_PROG0 = 6;
    localparam int EN_PROG1 = 7;

    // Time base fields
    localparam int TB_DIV_LSB = 0;
    localparam int TB_SYNTH = 3;
    localparam int TB_WAKE_SMI = 4;

    // Stop configuration fields
    localparam int SC_HALT_STOP = 0;
    localparam int SC_HALT_SLOW_ONLY = 1;
    localparam int SC_GATE_CLK = 2;
    localparam int SC_REQ_ON_CHANGE = 3;
    localparam int SC_DLY_LSB = 4;
    localparam int SC_WAIT_ACK = 7;
    localparam int SC_IMMEDIATE = 8;
    localparam int SC_RESET_METHOD = 9;

    // Command bits
    localparam int CMD_SLOW = 0;
    localparam int CMD_FAST = 1;
    localparam int CMD_STOP = 2;

    // Interrupt status bits
    localparam int IRQ_TRAP = 0;
    localparam int IRQ_WAKE_A = 1;
    localparam int IRQ_STOPPED = 2;
    localparam int IRQ_RESTARTED = 3;

    // Reset values
    localparam logic [7:0] RESTART_EN_RST = 8'h00;
    localparam logic [7:0] TIME_BASE_RST = 8'h03;
    localparam logic [9:0] STOP_CFG_RST = 10'h000;

    // Cycle ready follows the management interrupt by this many clocks
    localparam logic [2:0] RDY_DELAY = 3'h4;

    // Release delays in microseconds, index is the 3-bit delay code
    localparam int unsigned DLY_US [8] =
        '{0, 32, 64, 125, 250, 500, 1000, 2000};
    // Reset-method hold time in microseconds
    localparam int unsigned RESET_HOLD_US = 1000;
    // Microsecond prescale from the fixed system clock
    localparam int unsigned CYC_PER_US = 1000000 / CLK_PS;
    localparam logic [6:0] US_TICK_LAST = 7'(CYC_PER_US - 1);

    // Fixed restart ranges: lower and upper inclusive bounds; keyboard ports are two single addresses
    localparam logic [9:0] COM1_LO = 10'h3F8;
    localparam logic [9:0] COM1_HI = 10'h3FF;
    localparam logic [9:0] COM2_LO = 10'h2F8;
    localparam logic [9:0] COM2_HI = 10'h2FF;
    localparam logic [9:0] LPT_LO = 10'h378;
    localparam logic [9:0] LPT_HI = 10'h37F;
    localparam logic [9:0] HD1_LO = 10'h1F0;
    localparam logic [9:0] HD1_HI = 10'h1F7;
    localparam logic [9:0] FD1_LO = 10'h3F0;
    localparam logic [9:0] FD1_HI = 10'h3F7;
    localparam logic [9:0] HD2_LO = 10'h170;
    localparam logic [9:0] HD2_HI = 10'h177;
    localparam logic [9:0] FD2_LO = 10'h370;
    localparam logic [9:0] FD2_HI = 10'h377;
    localparam logic [9:0] VGA1_LO = 10'h3B0;
    localparam logic [9:0] VGA1_HI = 10'h3BB;
    localparam logic [9:0] VGA2_LO = 10'h3C0;
    localparam logic [9:0] VGA2_HI = 10'h3DF;
    localparam logic [9:0] KB_DATA = 10'h060;
    localparam logic [9:0] KB_CTRL = 10'h064;

    // Clock sequencer states
    typedef enum logic [2:0] {
        PMC_IDLE,
        PMC_REQ,
        PMC_ACK_WAIT,
        PMC_SWITCH,
        PMC_DELAY,
        PMC_STOPPED
    } pmc_seq_e;

endpackage

// ### src/pmc_restart_decode.sv
/*
 * Combinational decode of a local-bus I/O address against the enabled
 * fixed restart ranges and the two programmable ranges.
 * Assumes the address is stable while the I/O strobe is high.
 */
`timescale 1ns/1ps
module pmc_restart_decode (
    input wire logic [9:0] io_addr,
    input wire logic [7:0] enable,
    input wire logic [9:0] prog0_base,
    input wire logic [9:0] prog0_mask,
    input wire logic [9:0] prog1_base,
    input wire logic [9:0] prog1_mask,
    output logic hit
);

    // Inclusive range test
    function automatic logic in_range(input logic [9:0] a,
                                      input logic [9:0] lo,
                                      input logic [9:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Hit when any enabled group matches
    always_comb
    begin
        hit = 1'b0;
        // Serial ports
        if (enable[pmc_pkg::EN_COM1] &&
            in_range(io_addr, pmc_pkg::COM1_LO, pmc_pkg::COM1_HI))
            hit = 1'b1;
        if (enable[pmc_pkg::EN_COM2] &&
            in_range(io_addr, pmc_pkg::COM2_LO, pmc_pkg::COM2_HI))
            hit = 1'b1;
        // Parallel port
        if (enable[pmc_pkg::EN_LPT] &&
            in_range(io_addr, pmc_pkg::LPT_LO, pmc_pkg::LPT_HI))
            hit = 1'b1;
        // Keyboard data and control ports
        if (enable[pmc_pkg::EN_KB] &&
            (io_addr == pmc_pkg::KB_DATA || io_addr == pmc_pkg::KB_CTRL))
            hit = 1'b1;
        // Disk controllers, both channels
        if (enable[pmc_pkg::EN_DISK] &&
            (in_range(io_addr, pmc_pkg::HD1_LO, pmc_pkg::HD1_HI) ||
             in_range(io_addr, pmc_pkg::FD1_LO, pmc_pkg::FD1_HI) ||
             in_range(io_addr, pmc_pkg::HD2_LO, pmc_pkg::HD2_HI) ||
             in_range(io_addr, pmc_pkg::FD2_LO, pmc_pkg::FD2_HI)))
            hit = 1'b1;
        // Video I/O
        if (enable[pmc_pkg::EN_VGA] &&
            (in_range(io_addr, pmc_pkg::VGA1_LO, pmc_pkg::VGA1_HI) ||
             in_range(io_addr, pmc_pkg::VGA2_LO, pmc_pkg::VGA2_HI)))
            hit = 1'b1;
        // Programmable ranges: mask bits set are don't-care
        if (enable[pmc_pkg::EN_PROG0] &&
            ((io_addr & ~prog0_mask) == (prog0_base & ~prog0_mask)))
            hit = 1'b1;
        if (enable[pmc_pkg::EN_PROG1] &&
            ((io_addr & ~prog1_mask) == (prog1_base & ~prog1_mask)))
            hit = 1'b1;
    end

endmodule

// ### src/pmc_clk_div.sv
/*
 * CPU clock source: divides the system clock for slow speed, or passes
 * a full-rate enable, and gates the output low while gate_off is set.
 * Assumes divider changes only while the sequencer holds the switch step.
 */
`timescale 1ns/1ps
module pmc_clk_div (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic slow,
    input wire logic gate_off,
    input wire logic [2:0] div_sel,
    output logic cpu_clk
);

    typedef struct packed {
        logic [7:0] cnt;
        logic out;
    } pmc_div_s;

    pmc_div_s st;
    pmc_div_s next_st;
    logic [7:0] half; // Half period in system clocks

    ////////////////////////////////////////////////////////////////////////
    // Toggle output every half period; full speed toggles every clock
    always_comb
    begin
        next_st = st;
        half = 8'h01 << div_sel;
        if (gate_off)
        begin
            // Gated: hold low so the CPU sees no edges
            next_st.out = 1'b0;
            next_st.cnt = 8'h00;
        end
        else if (!slow)
        begin
            next_st.out = ~st.out;
            next_st.cnt = 8'h00;
        end
        else if (st.cnt + 8'h01 >= half)
        begin
            next_st.out = ~st.out;
            next_st.cnt = 8'h00;
        end
        else
        begin
            next_st.cnt = st.cnt + 8'h01;
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            st <= '0;
        else if (ce)
            st <= next_st;
    end

    assign cpu_clk = st.out;

endmodule

// ### src/pmc_clock_ctrl.sv
/*
 * Power-management I/O restart trap and CPU clock switching sequencer.
 * Holds the command registers, the trap timing, the slow/fast/stop
 * sequencer and the interrupt status.
 * Assumes the inactivity timer, wake decoding and halt detection are
 * provided by neighbouring logic as one-cycle pulses or levels.
 */
// The register offsets and the plain strobed port are this design's own decisions.
// Contract
// - Trapped I/O: claim locally, raise interrupt
// - Cycle ready four clocks after interrupt
// - Serial, parallel, keyboard, programmable restart ranges
// - Disk and video restart ranges
// - Slow on timer A or command
// - Wake A: fast, or interrupt in software mode
// - Internal divider or synthesizer select pin
// - Stop on halt, slow-only option, command
// - Only wake B restarts a stopped clock
// - Stop with request only, or gated clock
// - Immediate stop without request protocol
// - Optional stop request before frequency change
// - Optional wait for acknowledge bus cycle
// - Suspend acknowledge also serves as acknowledge
// - Coded release delay after frequency change
// - Reset method: release one millisecond later
`timescale 1ns/1ps
module pmc_clock_ctrl (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // Command port
    input wire logic [3:0] reg_addr,
    input wire logic [9:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [9:0] reg_rdata,
    // Local bus I/O cycle
    input wire logic io_cycle,
    input wire logic [9:0] io_addr,
    output logic local_device_claim,
    output logic cycle_ready,
    output logic smi_req,
    // Event sources
    input wire logic inactivity_timer_a,
    input wire logic wake_event_a,
    input wire logic wake_event_b,
    input wire logic halt_cycle,
    // CPU handshake
    input wire logic stop_clock_ack_cycle,
    input wire logic suspend_ack,
    output logic stop_clock_req,
    output logic cpu_clk,
    output logic synth_slow,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [7:0] restart_en;
        logic [9:0] prog0_base;
        logic [9:0] prog0_mask;
        logic [9:0] prog1_base;
        logic [9:0] prog1_mask;
        logic [7:0] time_base;
        logic [9:0] stop_cfg;
        logic [3:0] irq_stat;
        logic [3:0] irq_en;
        logic [9:0] rdata;
        logic trap_busy;
        logic [2:0] trap_cnt;
        logic claim;
        logic smi;
        logic rdy;
        pmc_pkg::pmc_seq_e seq;
        logic tgt_slow;   // Requested speed of the pending change
        logic tgt_stop;   // Pending change is a stop
        logic is_slow;    // Running speed
        logic gate;       // CPU clock gated off
        logic stop_req;
        logic synth;
        logic [6:0] us_pre;
        logic [11:0] us_cnt;
        logic irq;
    } pmc_ctrl_s;

    pmc_ctrl_s st;
    pmc_ctrl_s next_st;

    logic trap_hit;
    logic want_slow;
    logic want_fast;
    logic want_stop;
    logic [11:0] dly_target;
    logic [3:0] status_word;

    ////////////////////////////////////////////////////////////////////////
    // Restart address decode
    pmc_restart_decode u_decode (
        .io_addr(io_addr),
        .enable(st.restart_en),
        .prog0_base(st.prog0_base),
        .prog0_mask(st.prog0_mask),
        .prog1_base(st.prog1_base),
        .prog1_mask(st.prog1_mask),
        .hit(trap_hit)
    );

    // CPU clock generator; divider idles at full rate in synthesizer mode
    pmc_clk_div u_div (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .slow(st.is_slow && !st.time_base[pmc_pkg::TB_SYNTH]),
        .gate_off(st.gate),
        .div_sel(st.time_base[pmc_pkg::TB_DIV_LSB +: 3]),
        .cpu_clk(cpu_clk)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb
    begin
        next_st = st;
        status_word = {st.gate, st.stop_req, st.synth, st.is_slow};
        // Software commands arrive as a write to the command register
        want_slow = inactivity_timer_a ||
            (reg_wr && reg_addr == pmc_pkg::REG_COMMAND &&
             reg_wdata[pmc_pkg::CMD_SLOW]);
        want_fast = reg_wr && reg_addr == pmc_pkg::REG_COMMAND &&
            reg_wdata[pmc_pkg::CMD_FAST];
        want_stop = (reg_wr && reg_addr == pmc_pkg::REG_COMMAND &&
                     reg_wdata[pmc_pkg::CMD_STOP]) ||
            (halt_cycle && st.stop_cfg[pmc_pkg::SC_HALT_STOP] &&
             (!st.stop_cfg[pmc_pkg::SC_HALT_SLOW_ONLY] ||
              st.is_slow));
        // Wake A: hardware mode speeds up, software mode interrupts
        if (wake_event_a && !st.time_base[pmc_pkg::TB_WAKE_SMI])
            want_fast = 1'b1;
        // Release delay; reset method always holds for one millisecond
        if (st.stop_cfg[pmc_pkg::SC_RESET_METHOD])
            dly_target = 12'(pmc_pkg::RESET_HOLD_US);
        else
            dly_target = 12'(pmc_pkg::DLY_US[
                st.stop_cfg[pmc_pkg::SC_DLY_LSB +: 3]]);

        // Register writes
        next_st.rdata = 10'h000;
        if (reg_wr)
        begin
            case (reg_addr)
                pmc_pkg::REG_RESTART_EN:
                    next_st.restart_en = reg_wdata[7:0];
                pmc_pkg::REG_PROG0_BASE: next_st.prog0_base = reg_wdata;
                pmc_pkg::REG_PROG0_MASK: next_st.prog0_mask = reg_wdata;
                pmc_pkg::REG_PROG1_BASE: next_st.prog1_base = reg_wdata;
                pmc_pkg::REG_PROG1_MASK: next_st.prog1_mask = reg_wdata;
                pmc_pkg::REG_TIME_BASE:
                    next_st.time_base = reg_wdata[7:0];
                pmc_pkg::REG_STOP_CFG: next_st.stop_cfg = reg_wdata;
                pmc_pkg::REG_IRQ_EN: next_st.irq_en = reg_wdata[3:0];
                pmc_pkg::REG_IRQ_CLR:
                    next_st.irq_stat = st.irq_stat & ~reg_wdata[3:0];
                default: ;
            endcase
        end
        // Register reads, data valid the following cycle
        if (reg_rd)
        begin
            case (reg_addr)
                pmc_pkg::REG_RESTART_EN:
                    next_st.rdata = {2'h0, st.restart_en};
                pmc_pkg::REG_PROG0_BASE: next_st.rdata = st.prog0_base;
                pmc_pkg::REG_PROG0_MASK: next_st.rdata = st.prog0_mask;
                pmc_pkg::REG_PROG1_BASE: next_st.rdata = st.prog1_base;
                pmc_pkg::REG_PROG1_MASK: next_st.rdata = st.prog1_mask;
                pmc_pkg::REG_TIME_BASE:
                    next_st.rdata = {2'h0, st.time_base};
                pmc_pkg::REG_STOP_CFG: next_st.rdata = st.stop_cfg;
                pmc_pkg::REG_STATUS:
                    next_st.rdata = {st.seq != pmc_pkg::PMC_IDLE &&
                                     st.seq != pmc_pkg::PMC_STOPPED,
                                     5'h00, status_word};
                pmc_pkg::REG_IRQ_STAT:
                    next_st.rdata = {6'h00, st.irq_stat};
                pmc_pkg::REG_IRQ_EN: next_st.rdata = {6'h00, st.irq_en};
                default: next_st.rdata = 10'h000;
            endcase
        end

        // I/O restart trap: claim, interrupt, ready four clocks later
        next_st.rdy = 1'b0;
        next_st.smi = 1'b0;
        if (!st.trap_busy && io_cycle && trap_hit)
        begin
            next_st.trap_busy = 1'b1;
            next_st.claim = 1'b1;
            next_st.smi = 1'b1;
            next_st.trap_cnt = 3'h1;
            next_st.irq_stat[pmc_pkg::IRQ_TRAP] = 1'b1;
        end
        else if (st.trap_busy)
        begin
            if (st.trap_cnt == pmc_pkg::RDY_DELAY)
            begin
                next_st.rdy = 1'b1;
                next_st.claim = 1'b0;
                next_st.trap_busy = 1'b0;
            end
            else
                next_st.trap_cnt = st.trap_cnt + 3'h1;
        end
        // Wake A in software mode raises an interrupt instead
        if (wake_event_a && st.time_base[pmc_pkg::TB_WAKE_SMI])
        begin
            next_st.smi = 1'b1;
            next_st.irq_stat[pmc_pkg::IRQ_WAKE_A] = 1'b1;
        end

        // Microsecond prescale of the fixed system clock
        if (st.us_pre == pmc_pkg::US_TICK_LAST)
            next_st.us_pre = 7'h00;
        else
            next_st.us_pre = st.us_pre + 7'h01;

        // Clock change sequencer
        case (st.seq)
            pmc_pkg::PMC_IDLE:
            begin
                // One change at a time: stop wins over speed, fast over slow
                if (want_stop || want_slow != want_fast ||
                    (want_slow && want_fast))
                begin
                    next_st.tgt_stop = want_stop;
                    next_st.tgt_slow = want_slow && !want_fast;
                    if (want_stop && st.stop_cfg[pmc_pkg::SC_IMMEDIATE])
                    begin
                        next_st.gate = 1'b1;
                        next_st.seq = pmc_pkg::PMC_STOPPED;
                        next_st.irq_stat[pmc_pkg::IRQ_STOPPED] = 1'b1;
                    end
                    else if (!want_stop &&
                             (want_slow && !want_fast) == st.is_slow)
                        next_st.seq = pmc_pkg::PMC_IDLE;
                    else if (want_stop ||
                             st.stop_cfg[pmc_pkg::SC_REQ_ON_CHANGE] ||
                             st.stop_cfg[pmc_pkg::SC_RESET_METHOD])
                    begin
                        next_st.stop_req = 1'b1;
                        next_st.seq = pmc_pkg::PMC_REQ;
                    end
                    else
                        next_st.seq = pmc_pkg::PMC_SWITCH;
                end
            end
            pmc_pkg::PMC_REQ:
            begin
                if (st.stop_cfg[pmc_pkg::SC_WAIT_ACK] &&
                    !st.stop_cfg[pmc_pkg::SC_RESET_METHOD])
                    next_st.seq = pmc_pkg::PMC_ACK_WAIT;
                else
                    next_st.seq = pmc_pkg::PMC_SWITCH;
            end
            pmc_pkg::PMC_ACK_WAIT:
            begin
                // Either acknowledge form is accepted
                if (stop_clock_ack_cycle || suspend_ack)
                    next_st.seq = pmc_pkg::PMC_SWITCH;
            end
            pmc_pkg::PMC_SWITCH:
            begin
                next_st.us_cnt = 12'h000;
                next_st.us_pre = 7'h00;
                if (st.tgt_stop)
                begin
                    // Request stays; optionally gate the clock too
                    next_st.gate = st.stop_cfg[pmc_pkg::SC_GATE_CLK];
                    next_st.seq = pmc_pkg::PMC_STOPPED;
                    next_st.irq_stat[pmc_pkg::IRQ_STOPPED] = 1'b1;
                end
                else
                begin
                    next_st.is_slow = st.tgt_slow;
                    next_st.synth = st.tgt_slow &&
                        st.time_base[pmc_pkg::TB_SYNTH];
                    if (dly_target == 12'h000 || !st.stop_req)
                    begin
                        next_st.stop_req = 1'b0;
                        next_st.seq = pmc_pkg::PMC_IDLE;
                    end
                    else
                        next_st.seq = pmc_pkg::PMC_DELAY;
                end
            end
            pmc_pkg::PMC_DELAY:
            begin
                // Count whole microseconds; prescale restarted at switch
                if (st.us_pre == pmc_pkg::US_TICK_LAST)
                    next_st.us_cnt = st.us_cnt + 12'h001;
                if (st.us_cnt >= dly_target)
                begin
                    next_st.stop_req = 1'b0;
                    next_st.seq = pmc_pkg::PMC_IDLE;
                end
            end
            pmc_pkg::PMC_STOPPED:
            begin
                // Software cannot restart; only wake B
                if (wake_event_b)
                begin
                    next_st.gate = 1'b0;
                    next_st.stop_req = 1'b0;
                    next_st.seq = pmc_pkg::PMC_IDLE;
                    next_st.irq_stat[pmc_pkg::IRQ_RESTARTED] = 1'b1;
                end
            end
            default: next_st.seq = pmc_pkg::PMC_IDLE;
        endcase

        next_st.irq = |(next_st.irq_stat & next_st.irq_en);
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st <= '0;
            st.restart_en <= pmc_pkg::RESTART_EN_RST;
            st.time_base <= pmc_pkg::TIME_BASE_RST;
            st.stop_cfg <= pmc_pkg::STOP_CFG_RST;
            st.seq <= pmc_pkg::PMC_IDLE;
        end
        else if (ce)
            st <= next_st;
    end

    assign reg_rdata = st.rdata;
    assign local_device_claim = st.claim;
    assign cycle_ready = st.rdy;
    assign smi_req = st.smi;
    assign stop_clock_req = st.stop_req;
    assign synth_slow = st.synth;
    assign irq = st.irq;

endmodule

// ### verif/pmc_clock_ctrl_properties.sv
/* Trap timing checker for pmc_clock_ctrl.
   Sees the top ports only; bound at the foot. */
`timescale 1ns/1ps
module pmc_props (
    input wire logic clk,
    input wire logic rst,
    input wire logic io_cycle,
    input wire logic local_device_claim,
    input wire logic cycle_ready,
    input wire logic smi_req
);
default clocking @(posedge clk); endclocking
default disable iff (rst);
claim_smi_a: assert property ($rose(local_device_claim) |-> smi_req)
    else $error("claim without interrupt");
trap_cause_a: assert property ($rose(local_device_claim) |-> $past(io_cycle))
    else $error("claim without I/O cycle");
idle_claim_a: assert property (!local_device_claim && !io_cycle |=> !local_device_claim)
    else $error("claim from idle bus");
claim_hold_a: assert property ($rose(local_device_claim) |->
    local_device_claim [*4] ##1 cycle_ready)
    else $error("claim length wrong");
ready_delay_a: assert property (cycle_ready |-> $past(smi_req, 4))
    else $error("ready not four clocks after interrupt");
claim_end_a: assert property ($fell(local_device_claim) |-> cycle_ready)
    else $error("claim dropped without ready");
ready_pulse_a: assert property (cycle_ready |=> !cycle_ready)
    else $error("ready longer than a cycle");
ready_free_a: assert property (cycle_ready |-> !local_device_claim)
    else $error("claim still high at ready");
endmodule
bind pmc_clock_ctrl pmc_props pmc_props_i (.clk(clk), .rst(rst),
    .io_cycle(io_cycle), .local_device_claim(local_device_claim),
    .cycle_ready(cycle_ready), .smi_req(smi_req));

// ### verif/pmc_cpu_model.sv
/* Host CPU stand-in answering the stop-clock request.
   Assumes the request is a registered level. */
`timescale 1ns/1ps
module pmc_cpu_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic use_susp,
    input wire logic stop_clock_req,
    output logic stop_clock_ack_cycle,
    output logic suspend_ack
);
int n; // Cycles since the request rose
// Answer 20 cycles late, like a slow CPU
always @(posedge clk or posedge rst)
    if (rst)
    begin
        n <= 0;
        stop_clock_ack_cycle <= 1'b0;
        suspend_ack <= 1'b0;
    end
    else
    begin
        n <= stop_clock_req ? n + 1 : 0;
        stop_clock_ack_cycle <= !use_susp && n == 20;
        suspend_ack <= use_susp && stop_clock_req && n >= 20;
    end
endmodule

// ### verif/pmc_clock_ctrl_tb.sv
/* Self-checking bench for pmc_clock_ctrl.
   Assumes the CPU stand-in pmc_cpu_model. */
`timescale 1ns/1ps
module pmc_clock_ctrl_tb;
logic clk = 1'b0, rst = 1'b1, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
logic io_cycle = 1'b0, use_susp = 1'b0, stop_clock_req, smi_req, irq;
logic local_device_claim, cycle_ready, cpu_clk, synth_slow;
logic stop_clock_ack_cycle, suspend_ack;
logic [3:0] reg_addr = 4'h0, ev = 4'h0;
logic [9:0] reg_wdata = 10'h000, io_addr = 10'h000, reg_rdata, a;
logic [7:0] en;
logic [31:0] lf = 32'h0C1B;
int n_mismatch = 0, checked = 0, c;
// Range edges; the last two sit just outside
logic [9:0] eg [22] = '{10'h3F8, 10'h2FF, 10'h378, 10'h37F, 10'h1F0,
    10'h1F7, 10'h3F0, 10'h3F7, 10'h170, 10'h177, 10'h370, 10'h377,
    10'h3B0, 10'h3BB, 10'h3C0, 10'h3DF, 10'h060, 10'h064, 10'h10F,
    10'h200, 10'h2F7, 10'h3E0};
wire logic inactivity_timer_a = ev[0];
wire logic wake_event_a = ev[1];
wire logic wake_event_b = ev[2];
wire logic halt_cycle = ev[3];
always #5 clk = ~clk;
pmc_clock_ctrl pmc_clock_ctrl_i (.*);
pmc_cpu_model pmc_cpu_model_i (.*);
////////////////////////////////////////////////////////////////////////
function automatic logic [31:0] nx(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
endfunction
// Reference decode; prog0 is 100-10F, prog1 is 200
function automatic bit hit(logic [9:0] x, logic [7:0] e);
    return (e[0] && x inside {[10'h3F8:10'h3FF]})
        || (e[1] && x inside {[10'h2F8:10'h2FF]})
        || (e[2] && x inside {[10'h378:10'h37F]})
        || (e[3] && x inside {[10'h1F0:10'h1F7], [10'h3F0:10'h3F7],
            [10'h170:10'h177], [10'h370:10'h377]})
        || (e[4] && x inside {[10'h3B0:10'h3BB], [10'h3C0:10'h3DF]})
        || (e[5] && x inside {10'h060, 10'h064})
        || (e[6] && x[9:4] == 6'h10) || (e[7] && x == 10'h200);
endfunction
task chk(string n, logic [31:0] e, logic [31:0] s);
    checked++;
    if (s !== e)
    begin
        n_mismatch++;
        $display("MISMATCH %s expected %0h seen %0h", n, e, s);
    end
endtask
task summarize;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
        $display("All tests passed");
    else
        $display("Some tests failed");
    $finish;
endtask
task wr(logic [3:0] ad, logic [9:0] d);
    @(posedge clk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
endtask
task rd(logic [3:0] ad, logic [9:0] e);
    @(posedge clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("reg", e, reg_rdata);
endtask
task pulse(int b);
    @(posedge clk);
    ev[b] <= 1'b1;
    @(posedge clk);
    ev[b] <= 1'b0;
endtask
// Bounded wait; running out ends the run
task automatic wt(ref logic s, input logic v, input int lim);
    for (c = 0; c < lim && s !== v; c++)
        @(posedge clk) #1;
    if (s !== v)
    begin
        chk("wait", v, s);
        summarize();
    end
endtask
task trap(logic [9:0] x, bit h);
    @(posedge clk);
    io_cycle <= 1'b1;
    io_addr <= x;
    @(posedge clk);
    io_cycle <= 1'b0;
    for (int i = 1; i < 7; i++)
    begin
        #1 chk("claim", h && i < 5, local_device_claim);
        chk("smi", h && i == 1, smi_req);
        chk("ready", h && i == 5, cycle_ready);
        @(posedge clk);
    end
endtask
////////////////////////////////////////////////////////////////////////
initial
begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(pmc_pkg::REG_TIME_BASE, 10'h003);
    rd(pmc_pkg::REG_STOP_CFG, 10'h000);
    rd(4'hF, 10'h000);
    wr(pmc_pkg::REG_PROG0_BASE, 10'h100);
    wr(pmc_pkg::REG_PROG0_MASK, 10'h00F);
    wr(pmc_pkg::REG_PROG1_BASE, 10'h200);
    for (int k = 0; k < 80; k++)
    begin
        lf = nx(lf);
        en = (k < 30) ? 8'hFF : lf[7:0];
        a = (k % 3 == 2) ? lf[17:8] : eg[lf[15:8] % 22];
        wr(pmc_pkg::REG_RESTART_EN, {2'h0, en});
        trap(a, hit(a, en));
    end
    $display("trap ranges done");
    wr(pmc_pkg::REG_IRQ_EN, 10'h001);
    #1 chk("irq", 1, irq);
    wr(pmc_pkg::REG_IRQ_CLR, 10'h001);
    #1 chk("irq", 0, irq);
    wr(pmc_pkg::REG_IRQ_EN, 10'h000);
    rd(pmc_pkg::REG_IRQ_STAT, 10'h000);
    $display("interrupt done");
    wr(pmc_pkg::REG_TIME_BASE, 10'h00B);
    wr(pmc_pkg::REG_STOP_CFG, 10'h098);
    pulse(0);
    wt(stop_clock_req, 1'b1, 10);
    wt(stop_clock_req, 1'b0, 4000);
    chk("hold", 1, c >= 3220 && c <= 3330);
    chk("synth", 1, synth_slow);
    use_susp <= 1'b1;
    wr(pmc_pkg::REG_COMMAND, 10'h002);
    wt(stop_clock_req, 1'b1, 10);
    wt(stop_clock_req, 1'b0, 4000);
    chk("hold", 1, c >= 3220 && c <= 3330);
    chk("synth", 0, synth_slow);
    $display("speed change done");
    wr(pmc_pkg::REG_STOP_CFG, 10'h005);
    pulse(3);
    wt(stop_clock_req, 1'b1, 10);
    wr(pmc_pkg::REG_COMMAND, 10'h002);
    repeat (20) @(posedge clk);
    #1 chk("stopped", 1, stop_clock_req);
    chk("gated", 0, cpu_clk);
    pulse(2);
    wt(stop_clock_req, 1'b0, 100);
    wr(pmc_pkg::REG_TIME_BASE, 10'h010);
    pulse(1);
    #1 chk("smi", 1, smi_req);
    $display("stop and wake done");
    summarize();
end
endmodule
